// file: logic/ssl_pkg.sv
package ssl_pkg;
    localparam int CFG_W   = 8;
    localparam int FB_W    = 16;
    localparam int REF_W   = 15;
    localparam int SHIFT_W = 16;
    localparam int CNT_W   = 6;
    localparam int LEN_W   = 6;
    localparam int DATA_W  = 24;
    localparam int PRE_W   = 4;
    localparam int TMR_W   = 8;

    localparam logic [CNT_W-1:0] LEN_CFG     = 6'h08;
    localparam logic [CNT_W-1:0] LEN_FB      = 6'h10;
    localparam logic [CNT_W-1:0] LEN_REF_S   = 6'h0F;
    localparam logic [CNT_W-1:0] LEN_REF_L   = 6'h18;
    localparam logic [CNT_W-1:0] LEN_RST_MIN = 6'h09;
    localparam logic [CNT_W-1:0] LEN_RST_MAX = 6'h0D;
    localparam logic [CNT_W-1:0] LEN_SAT     = 6'h21;

    // Reference output select field in the configuration register.
    localparam int REFSEL_LSB = 0;
    localparam int REFSEL_W   = 3;
    localparam logic [REFSEL_W-1:0] REF_OFF   = 3'h0;
    localparam logic [REFSEL_W-1:0] REF_PASS  = 3'h1;
    localparam logic [REFSEL_W-1:0] REF_DIV2  = 3'h2;
    localparam logic [REFSEL_W-1:0] REF_DIV16 = 3'h5;

    localparam logic [CFG_W-1:0] CFG_RESET = 8'h04;
    localparam logic [FB_W-1:0]  FB_RESET  = 16'h0000;
    localparam logic [REF_W-1:0] REF_RESET = 15'h0001;

    localparam int CORE_CLK_PERIOD_NS = 25;
    localparam int SCK_HALF_NS        = 125;
    localparam int SEL_SETUP_NS       = 100;
    localparam int SEL_HIGH_NS        = 300;

    typedef enum logic [2:0] {TGT_NONE, TGT_CFG, TGT_FB, TGT_REF, TGT_RST} ssl_target_t;

    // Least time rounded up to whole core cycles, never below one.
    function automatic logic [TMR_W-1:0] ssl_cycles(input int ns);
        int c;
        c = (ns + CORE_CLK_PERIOD_NS - 1) / CORE_CLK_PERIOD_NS;
        if (c < 1)
        begin
            c = 1;
        end
        return TMR_W'(c);
    endfunction

    function automatic ssl_target_t ssl_decode(input logic [CNT_W-1:0] n);
        ssl_target_t t;
        t = TGT_NONE;
        if (n == LEN_CFG)
        begin
            t = TGT_CFG;
        end
        else if (n == LEN_FB)
        begin
            t = TGT_FB;
        end
        else if (n == LEN_REF_S || n == LEN_REF_L)
        begin
            t = TGT_REF;
        end
        else if (n >= LEN_RST_MIN && n <= LEN_RST_MAX)
        begin
            t = TGT_RST;
        end
        return t;
    endfunction
endpackage

// file: logic/ssl_link_if.sv
`timescale 1ns/1ps
interface ssl_link_if;
    logic shift_clk;
    logic port_select_n;
    logic serial_in;
    logic serial_out;
    logic serial_out_oe;

    modport dev
    (
        input  shift_clk,
        input  port_select_n,
        input  serial_in,
        output serial_out,
        output serial_out_oe
    );

    modport host
    (
        output shift_clk,
        output port_select_n,
        output serial_in,
        input  serial_out
    );
endinterface

// file: logic/ssl_device.sv
`timescale 1ns/1ps
module ssl_device
    import ssl_pkg::*;
(
    input  wire logic                 i_core_clk,
    input  wire logic                 i_reset_n,
    ssl_link_if.dev                   link,
    input  wire logic                 i_crystal_amp_input,
    output logic [CFG_W-1:0]          o_synth_config,
    output logic [FB_W-1:0]           o_feedback_divide_ratio,
    output logic [REF_W-1:0]          o_reference_divide_ratio,
    output logic                      o_reset_pattern,
    output logic                      o_ref_div_pulse,
    output logic                      o_buffered_reference_output
);
    logic                 sck_q;
    logic                 sel_n_q;
    logic                 sync_q;
    logic [SHIFT_W-1:0]   shift_q;
    logic [CNT_W-1:0]     count_q;
    logic                 out_q;
    logic                 out_oe_q;
    logic [CFG_W-1:0]     cfg_q;
    logic [FB_W-1:0]      fb_q;
    logic [REF_W-1:0]     ref_q;
    logic                 rst_pat_q;
    logic                 ref_in_q;
    logic [REF_W-1:0]     ref_cnt_q;
    logic                 ref_pulse_q;
    logic [PRE_W-1:0]     pre_q;
    logic                 buffered_reference_output_q;

    logic                 sck_rise;
    logic                 sck_fall;
    logic                 active;
    logic                 commit;
    logic                 ref_rise;
    ssl_target_t          target;
    logic [REFSEL_W-1:0]  refsel;
    logic [1:0]           pre_idx;

    assign sck_rise = link.shift_clk & ~sck_q;
    assign sck_fall = ~link.shift_clk & sck_q;
    assign active   = ~link.port_select_n & sync_q;
    // A select edge seen while the clock was high is a desynchronising event, not a commit.
    assign commit   = link.port_select_n & ~sel_n_q & sync_q & ~sck_q;
    assign target   = ssl_decode(count_q);
    assign ref_rise = i_crystal_amp_input & ~ref_in_q;
    assign refsel   = cfg_q[REFSEL_LSB +: REFSEL_W];
    assign pre_idx  = 2'(refsel - REF_DIV2);

    always_ff @(posedge i_core_clk)
    begin
        if (!i_reset_n)
        begin
            sck_q    <= 1'b0;
            sel_n_q  <= 1'b1;
            ref_in_q <= 1'b0;
        end
        else
        begin
            sck_q    <= link.shift_clk;
            sel_n_q  <= link.port_select_n;
            ref_in_q <= i_crystal_amp_input;
        end
    end

    always_ff @(posedge i_core_clk)
    begin
        if (!i_reset_n)
        begin
            sync_q <= 1'b1;
        end
        else if (link.port_select_n && !link.shift_clk)
        begin
            sync_q <= 1'b1;
        end
        else if ((link.port_select_n != sel_n_q) && sck_q)
        begin
            sync_q <= 1'b0;
        end
    end

    // Edges are found by sampling the shift clock on the core clock, so each level must last a core cycle; a stopped clock is fine.
    always_ff @(posedge i_core_clk)
    begin
        if (!i_reset_n)
        begin
            shift_q <= '0;
            count_q <= '0;
        end
        else if (link.port_select_n)
        begin
            count_q <= '0;
        end
        else if (active && sck_rise)
        begin
            shift_q <= {shift_q[SHIFT_W-2:0], link.serial_in};
            if (count_q != LEN_SAT)
            begin
                count_q <= count_q + 1'b1;
            end
        end
    end

    // The extra half stage: the output bit is re-timed to the falling clock.
    always_ff @(posedge i_core_clk)
    begin
        if (!i_reset_n)
        begin
            out_q    <= 1'b0;
            out_oe_q <= 1'b0;
        end
        else
        begin
            out_oe_q <= ~link.port_select_n;
            if (active && sck_fall)
            begin
                out_q <= shift_q[SHIFT_W-1];
            end
        end
    end

    assign link.serial_out    = out_q;
    assign link.serial_out_oe = out_oe_q;

    // Registers move only at commit, never during shifting.
    always_ff @(posedge i_core_clk)
    begin
        if (!i_reset_n)
        begin
            cfg_q     <= CFG_RESET;
            fb_q      <= FB_RESET;
            ref_q     <= REF_RESET;
            rst_pat_q <= 1'b0;
        end
        else
        begin
            rst_pat_q <= 1'b0;
            if (commit)
            begin
                unique case (target)
                    TGT_CFG:
                    begin
                        cfg_q <= shift_q[CFG_W-1:0];
                    end
                    TGT_FB:
                    begin
                        fb_q <= shift_q[FB_W-1:0];
                    end
                    TGT_REF:
                    begin
                        ref_q <= shift_q[REF_W-1:0];
                    end
                    TGT_RST:
                    begin
                        cfg_q     <= CFG_RESET;
                        fb_q      <= FB_RESET;
                        ref_q     <= REF_RESET;
                        rst_pat_q <= 1'b1;
                    end
                    TGT_NONE:
                    begin
                        rst_pat_q <= 1'b0;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge i_core_clk)
    begin
        if (!i_reset_n)
        begin
            ref_cnt_q   <= REF_RESET;
            ref_pulse_q <= 1'b0;
        end
        else
        begin
            ref_pulse_q <= 1'b0;
            if (rst_pat_q)
            begin
                ref_cnt_q <= ref_q;
            end
            else if (ref_rise)
            begin
                // A ratio of one or zero pulses on every reference edge.
                if (ref_cnt_q <= REF_W'(1))
                begin
                    ref_cnt_q   <= ref_q;
                    ref_pulse_q <= 1'b1;
                end
                else
                begin
                    ref_cnt_q <= ref_cnt_q - 1'b1;
                end
            end
        end
    end

    always_ff @(posedge i_core_clk)
    begin
        if (!i_reset_n)
        begin
            pre_q    <= '0;
            buffered_reference_output_q <= 1'b0;
        end
        else
        begin
            if (ref_rise)
            begin
                pre_q <= pre_q + 1'b1;
            end
            if (refsel == REF_OFF)
            begin
                buffered_reference_output_q <= 1'b0;
            end
            else if (refsel == REF_PASS)
            begin
                buffered_reference_output_q <= ref_in_q;
            end
            else if (refsel <= REF_DIV16)
            begin
                buffered_reference_output_q <= pre_q[pre_idx];
            end
            else
            begin
                buffered_reference_output_q <= 1'b0;
            end
        end
    end

    assign o_synth_config              = cfg_q;
    assign o_feedback_divide_ratio     = fb_q;
    assign o_reference_divide_ratio    = ref_q;
    assign o_reset_pattern             = rst_pat_q;
    assign o_ref_div_pulse             = ref_pulse_q;
    assign o_buffered_reference_output = buffered_reference_output_q;
endmodule

// file: logic/ssl_host.sv
`timescale 1ns/1ps
module ssl_host
    import ssl_pkg::*;
(
    input  wire logic              i_core_clk,
    input  wire logic              i_reset_n,
    ssl_link_if.host               link,
    input  wire logic              i_start,
    input  wire logic [LEN_W-1:0]  i_len,
    input  wire logic [DATA_W-1:0] i_data,
    output logic                   o_busy,
    output logic                   o_done,
    output logic [DATA_W-1:0]      o_rx_data
);
    typedef enum logic [2:0] {ST_IDLE, ST_LEAD, ST_LOW, ST_HIGH, ST_TRAIL, ST_GAP} ssl_hstate_t;

    localparam logic [TMR_W-1:0] HALF_CYC  = ssl_cycles(SCK_HALF_NS);
    localparam logic [TMR_W-1:0] SETUP_CYC = ssl_cycles(SEL_SETUP_NS);
    localparam logic [TMR_W-1:0] GAP_CYC   = ssl_cycles(SEL_HIGH_NS);

    ssl_hstate_t        state_q;
    logic [TMR_W-1:0]   tmr_q;
    logic [LEN_W-1:0]   len_q;
    logic [LEN_W-1:0]   bit_q;
    logic [DATA_W-1:0]  tx_q;
    logic [DATA_W-1:0]  rx_q;
    logic               sck_q;
    logic               sel_n_q;
    logic               mosi_q;
    logic               busy_q;
    logic               done_q;
    logic               tmr_end;

    assign tmr_end = (tmr_q == TMR_W'(1));

    always_ff @(posedge i_core_clk)
    begin
        if (!i_reset_n)
        begin
            state_q <= ST_IDLE;
            tmr_q   <= TMR_W'(1);
            len_q   <= '0;
            bit_q   <= '0;
            tx_q    <= '0;
            rx_q    <= '0;
            sck_q   <= 1'b0;
            sel_n_q <= 1'b1;
            mosi_q  <= 1'b0;
            busy_q  <= 1'b0;
            done_q  <= 1'b0;
        end
        else
        begin
            done_q <= 1'b0;
            if (!tmr_end)
            begin
                tmr_q <= tmr_q - 1'b1;
            end
            unique case (state_q)
                ST_IDLE:
                begin
                    if (i_start)
                    begin
                        // Data is left aligned so the first bit sent is the MSB.
                        tx_q    <= i_data << (DATA_W - int'(i_len));
                        len_q   <= i_len;
                        bit_q   <= '0;
                        sel_n_q <= 1'b0;
                        busy_q  <= 1'b1;
                        tmr_q   <= SETUP_CYC;
                        state_q <= ST_LEAD;
                    end
                end
                ST_LEAD:
                begin
                    if (tmr_end)
                    begin
                        tmr_q   <= HALF_CYC;
                        state_q <= (len_q == '0) ? ST_TRAIL : ST_LOW;
                        mosi_q  <= tx_q[DATA_W-1];
                        tx_q    <= {tx_q[DATA_W-2:0], 1'b0};
                    end
                end
                ST_LOW:
                begin
                    if (tmr_end)
                    begin
                        sck_q   <= 1'b1;
                        rx_q    <= {rx_q[DATA_W-2:0], link.serial_out};
                        tmr_q   <= HALF_CYC;
                        state_q <= ST_HIGH;
                    end
                end
                ST_HIGH:
                begin
                    if (tmr_end)
                    begin
                        sck_q <= 1'b0;
                        tmr_q <= HALF_CYC;
                        bit_q <= bit_q + 1'b1;
                        if (bit_q == len_q - 1'b1)
                        begin
                            state_q <= ST_TRAIL;
                        end
                        else
                        begin
                            mosi_q  <= tx_q[DATA_W-1];
                            tx_q    <= {tx_q[DATA_W-2:0], 1'b0};
                            state_q <= ST_LOW;
                        end
                    end
                end
                ST_TRAIL:
                begin
                    if (tmr_end)
                    begin
                        sel_n_q <= 1'b1;
                        tmr_q   <= GAP_CYC;
                        state_q <= ST_GAP;
                    end
                end
                ST_GAP:
                begin
                    if (tmr_end)
                    begin
                        busy_q  <= 1'b0;
                        done_q  <= 1'b1;
                        state_q <= ST_IDLE;
                    end
                end
            endcase
        end
    end

    assign link.shift_clk     = sck_q;
    assign link.port_select_n = sel_n_q;
    assign link.serial_in     = mosi_q;
    assign o_busy             = busy_q;
    assign o_done             = done_q;
    assign o_rx_data          = rx_q;
endmodule

// file: bench/ssl_link_sva.sv
`timescale 1ns/1ps
module ssl_link_sva
(
    input wire logic i_core_clk,
    input wire logic i_reset_n,
    input wire logic shift_clk,
    input wire logic port_select_n,
    input wire logic serial_in,
    input wire logic serial_out,
    input wire logic serial_out_oe
);
    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (!i_reset_n);

    a_float_idle: assert property (port_select_n [*3] |-> !serial_out_oe)
        else $error("serial output driven while deselected");
    a_release_out: assert property ($rose(port_select_n) |-> ##[1:2] !serial_out_oe)
        else $error("serial output not released after select rise");
    a_drive_on_sel: assert property ($fell(port_select_n) |-> ##[1:2] serial_out_oe)
        else $error("serial output not driven after select fall");
    a_out_low_clk: assert property (serial_out_oe && $past(serial_out_oe)
        && $changed(serial_out) |-> !shift_clk)
        else $error("serial output moved while shift clock high");
    // Four quiet cycles prove the shift path holds state without any clock activity.
    a_static_hold: assert property (
        (!port_select_n && serial_out_oe && $stable(shift_clk)) [*4] |-> $stable(serial_out))
        else $error("serial output moved without a shift clock edge");
    a_sel_clk_low: assert property ($changed(port_select_n)
        |-> !shift_clk && !$past(shift_clk))
        else $error("select moved while shift clock high");
    a_clk_in_frame: assert property ($rose(shift_clk) |-> !port_select_n)
        else $error("shift clock pulsed outside a frame");
    a_sel_high_gap: assert property ($rose(port_select_n) |-> port_select_n [*8])
        else $error("select high time too short");
    a_din_settled: assert property ($rose(shift_clk)
        |-> $stable(serial_in) ##1 $stable(serial_in))
        else $error("serial input moved at the sampling edge");
    a_clk_pulse: assert property ($rose(shift_clk) |-> shift_clk [*4] ##[1:3] !shift_clk)
        else $error("shift clock high time wrong");
endmodule

// file: bench/synth_serial_register_loader_tb.sv
`timescale 1ns/1ps
module synth_serial_register_loader_tb import ssl_pkg::*;;
    logic              i_core_clk;
    logic              i_reset_n;
    logic              xtal;
    logic              start;
    logic [LEN_W-1:0]  len;
    logic [DATA_W-1:0] data;
    logic [CFG_W-1:0]  cfg;
    logic [FB_W-1:0]   fb;
    logic [REF_W-1:0]  refr;
    logic              rst_pat;
    logic              ref_pulse;
    logic              buffered_reference_output;
    logic              busy;
    logic              done;
    logic [DATA_W-1:0] rx;
    logic [38:0]       m_regs;
    logic [DATA_W-1:0] d;
    int                rst_hits;
    int                err_total;
    int                check_count;
    int                pulses;
    int                rises;
    int                lens [20] = '{8, 16, 15, 24, 9, 10, 11, 12, 13, 0,
                                     1, 7, 14, 17, 23, 4, 20, 8, 16, 24};

    ssl_link_if link ();
    ssl_device u_ssl_device (.i_core_clk(i_core_clk), .i_reset_n(i_reset_n), .link(link),
        .i_crystal_amp_input(xtal), .o_synth_config(cfg), .o_feedback_divide_ratio(fb),
        .o_reference_divide_ratio(refr), .o_reset_pattern(rst_pat),
        .o_ref_div_pulse(ref_pulse), .o_buffered_reference_output(buffered_reference_output));
    ssl_host u_ssl_host (.i_core_clk(i_core_clk), .i_reset_n(i_reset_n), .link(link),
        .i_start(start), .i_len(len), .i_data(data), .o_busy(busy), .o_done(done),
        .o_rx_data(rx));
    ssl_link_sva u_ssl_link_sva (.i_core_clk(i_core_clk), .i_reset_n(i_reset_n),
        .shift_clk(link.shift_clk), .port_select_n(link.port_select_n),
        .serial_in(link.serial_in), .serial_out(link.serial_out),
        .serial_out_oe(link.serial_out_oe));

    initial
    begin
        i_core_clk = 1'b0;
        forever #12.5 i_core_clk = ~i_core_clk;
    end

    // The reset pulse lasts one cycle, so pulses are counted here for the end-of-transfer check.
    always @(posedge i_core_clk)
    begin
        if (!i_reset_n)
        begin
            rst_hits <= 0;
        end
        else if (rst_pat === 1'b1)
        begin
            rst_hits <= rst_hits + 1;
        end
    end

    task automatic check(input logic [39:0] act, input logic [39:0] exp);
        check_count++;
        if (act !== exp)
        begin
            err_total++;
            $display("unexpected at %0t ns: got %h expected %h", $time, act, exp);
        end
    endtask

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    function automatic logic [38:0] expect_regs(input int n, input logic [23:0] v,
                                                input logic [38:0] prev);
        logic [38:0] r;
        r = prev;
        if (n == 8)
            r[38:31] = v[7:0];
        else if (n == 16)
            r[30:15] = v[15:0];
        else if (n == 15 || n == 24)
            r[14:0] = v[14:0];
        else if (n >= 9 && n <= 13)
            r = {CFG_RESET, FB_RESET, REF_RESET};
        return r;
    endfunction

    // Selects 1 to 5 pass or halve per step, every other select holds the output low.
    function automatic int expect_rises(input int sel, input int edges);
        int r;
        r = 0;
        if (sel == 1)
            r = edges;
        else if (sel >= 2 && sel <= 5)
            r = edges >> (sel - 1);
        return r;
    endfunction

    task automatic xfer(input int n, input logic [23:0] v);
        int w;
        int seen;
        seen = rst_hits;
        @(negedge i_core_clk);
        start = 1'b1;
        len = LEN_W'(n);
        data = v;
        @(negedge i_core_clk);
        start = 1'b0;
        check(busy, 1);
        // A second start raised in mid-transfer must be ignored by the busy host.
        for (w = 0; w < 2000 && done !== 1'b1; w++)
        begin
            if (link.port_select_n === 1'b0)
                check({1'b0, cfg, fb, refr}, {1'b0, m_regs});
            @(negedge i_core_clk);
            start = (w == 2);
        end
        check(w < 2000, 1);
        check(busy, 0);
        m_regs = expect_regs(n, v, m_regs);
        check({1'b0, cfg, fb, refr}, {1'b0, m_regs});
        check(rst_hits - seen, (n >= 9 && n <= 13) ? 1 : 0);
    endtask

    // Windows are whole multiples of the output period, so start phase does not matter.
    task automatic ref_run(input int edges);
        logic prev;
        prev = buffered_reference_output;
        pulses = 0;
        rises = 0;
        for (int k = 0; k < edges * 4; k++)
        begin
            @(negedge i_core_clk);
            if (ref_pulse === 1'b1)
                pulses++;
            if (buffered_reference_output === 1'b1 && prev === 1'b0)
                rises++;
            prev = buffered_reference_output;
            // The reference runs at a quarter of the core clock, so pass-through stays legal.
            xtal = (k % 4) < 2;
        end
    endtask

    initial
    begin
        err_total = 0;
        check_count = 0;
        i_reset_n = 1'b0;
        xtal = 1'b0;
        start = 1'b0;
        len = '0;
        data = '0;
        m_regs = {CFG_RESET, FB_RESET, REF_RESET};
        void'($urandom(32'h64f3_6b0a));
        repeat (2) @(negedge i_core_clk);
        i_reset_n = 1'b1;
        @(negedge i_core_clk);
        check({1'b0, cfg, fb, refr}, {1'b0, m_regs});
        check(link.shift_clk, 0);
        ref_run(32);
        check(rises, 4);
        $display("test reset_state finished");
        xfer(15, 24'h00_0005);
        ref_run(10);
        ref_run(20);
        check(pulses, 4);
        $display("test ref_counter finished");
        d = DATA_W'($urandom);
        xfer(24, d);
        check(rx[7:0], d[23:16]);
        $display("test wrap_around finished");
        xfer(8, DATA_W'($urandom));
        $display("test config_only finished");
        for (int s = 0; s < 8; s++)
        begin
            xfer(8, DATA_W'(s));
            ref_run(16);
            check(rises, expect_rises(s, 16));
        end
        $display("test ref_modes finished");
        repeat (40)
            xfer(lens[$urandom_range(19)], DATA_W'($urandom));
        $display("test random_lengths finished");
        summarize();
    end

    initial
    begin
        repeat (50000) @(posedge i_core_clk);
        err_total++;
        summarize();
    end
endmodule
